// ==== hw/sbc_pkg.sv ====
// Constants, state codes and timing counts shared by the two-wire client interface
package sbc_pkg;

  localparam logic [6:0]  OWN_ADDR    = 7'h28;
  localparam logic [3:0]  BYTE_BITS   = 4'h8;
  localparam int          PTR_W       = 8;
  localparam int          CNT_W       = 20;
  localparam int          FIFO_DEPTH  = 8;

  // Times in their own units, cycle counts rounded up from the clock rate
  localparam longint      CLK_HZ      = 64'h0000_0000_017D_7840;
  localparam longint      T_PWRUP_MS  = 64'h0000_0000_0000_000A;
  localparam longint      T_TOUT_MS   = 64'h0000_0000_0000_001E;
  localparam longint      T_IDLE_US   = 64'h0000_0000_0000_0096;
  localparam int          PWRUP_CYC   = int'((T_PWRUP_MS * CLK_HZ + 999) / 1000);
  localparam int          TOUT_CYC    = int'((T_TOUT_MS * CLK_HZ + 999) / 1000);
  localparam int          IDLE_CYC    = int'((T_IDLE_US * CLK_HZ + 999_999) / 1_000_000);

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_AACK = 8'h04,
    ST_WR   = 8'h08,
    ST_WACK = 8'h10,
    ST_RD   = 8'h20,
    ST_RACK = 8'h40,
    ST_SKIP = 8'h80
  } sbc_state_e;

endpackage

// ==== hw/sbc_fifo.sv ====
// Write-stream FIFO with a registered output stage
module sbc_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 8
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem_reg [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0]   cnt_reg;
  logic          push;
  logic          pop;

  // Output slot is refilled only when empty or being taken, so a stalled drain fills storage
  assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
  assign push       = in_valid_i & in_ready_o;
  assign pop        = (cnt_reg != '0) & (~out_valid_o | out_ready_i);

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg  <= '0;
    end else begin
      if (push) begin
        wptr_reg <= (wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + AW'(1);
      end
      if (pop) begin
        rptr_reg <= (rptr_reg == AW'(DEPTH - 1)) ? '0 : rptr_reg + AW'(1);
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else if (pop) begin
      out_valid_o <= 1'b1;
      out_data_o  <= mem_reg[rptr_reg];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end

endmodule // sbc_fifo

// ==== hw/sbc_smbus_client.sv ====
// Two-wire bus client: condition detection, byte engine, register pointer and write stream
module sbc_smbus_client #(
  parameter int PWRUP_CYC  = sbc_pkg::PWRUP_CYC,
  parameter int TOUT_CYC   = sbc_pkg::TOUT_CYC,
  parameter int IDLE_CYC   = sbc_pkg::IDLE_CYC,
  parameter int FIFO_DEPTH = sbc_pkg::FIFO_DEPTH
) (
  input  wire logic                      mclk_i,
  input  wire logic                      resetn_i,
  input  wire logic                      serial_bus_clock_pin_i,
  input  wire logic                      sda_i,
  output logic                           sda_o,
  output logic                           sda_oe_o,
  input  wire logic                      tout_en_i,
  input  wire logic                      deep_sleep_i,
  output logic [sbc_pkg::PTR_W-1:0]      rd_addr_o,
  input  wire logic [sbc_pkg::PTR_W-1:0] rd_data_i,
  output logic                           rd_strobe_o,
  output logic                           wr_valid_o,
  output logic [sbc_pkg::PTR_W-1:0]      wr_addr_o,
  output logic [sbc_pkg::PTR_W-1:0]      wr_data_o,
  input  wire logic                      wr_ready_i,
  output logic                           bus_ready_o
);

  localparam int PW = sbc_pkg::PTR_W;
  localparam int CW = sbc_pkg::CNT_W;

  // Bit 1 is the bus clock, bit 0 the data line
  logic [1:0]          sync1_reg;
  logic [1:0]          sync2_reg;
  logic [1:0]          sync3_reg;
  logic [1:0]          line_reg;
  logic [1:0]          line_prev_reg;
  logic                scl;
  logic                sda;
  logic                scl_rise;
  logic                scl_fall;
  logic                start_det;
  logic                stop_det;

  logic [CW-1:0]       pwr_cnt_reg;
  logic                pwr_done_reg;
  logic [CW-1:0]       low_cnt_reg;
  logic [CW-1:0]       idle_cnt_reg;
  logic                tout_fire;
  logic                idle_fire;
  logic                bus_reset;
  logic                step_ok;

  sbc_pkg::sbc_state_e state_reg;
  logic [3:0]          bit_cnt_reg;
  logic [7:0]          shift_reg;
  logic [7:0]          tx_reg;
  logic                dir_rd_reg;
  logic                first_reg;
  logic                host_ack_reg;
  logic                ld_pend_reg;
  logic                sda_oe_reg;
  logic                sda_out_reg;
  logic                rd_strobe_reg;
  logic [PW-1:0]       ptr_reg;

  logic                byte_full;
  logic                addr_hit;
  logic                wr_byte_done;
  logic                ptr_load;
  logic                push;
  logic                rd_next;
  logic                load_now;
  logic                fifo_in_ready;

  // Pin synchroniser: a level is taken only once the second and third stages agree
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_reg     <= 2'h3;
      sync2_reg     <= 2'h3;
      sync3_reg     <= 2'h3;
      line_reg      <= 2'h3;
      line_prev_reg <= 2'h3;
    end else begin
      sync1_reg     <= {serial_bus_clock_pin_i, sda_i};
      sync2_reg     <= sync1_reg;
      sync3_reg     <= sync2_reg;
      line_reg      <= (line_reg & (sync2_reg ^ sync3_reg)) | (sync3_reg & ~(sync2_reg ^ sync3_reg));
      line_prev_reg <= line_reg;
    end
  end

  assign scl       = line_reg[1];
  assign sda       = line_reg[0];
  assign scl_rise  = scl & ~line_prev_reg[1];
  assign scl_fall  = ~scl & line_prev_reg[1];
  assign start_det = scl & line_prev_reg[1] & ~sda & line_prev_reg[0];
  assign stop_det  = scl & line_prev_reg[1] & sda & ~line_prev_reg[0];

  // Power-up quiet interval; the bus is ignored until it has run out
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwr_cnt_reg  <= '0;
      pwr_done_reg <= 1'b0;
    end else if (!pwr_done_reg) begin
      pwr_cnt_reg  <= pwr_cnt_reg + CW'(1);
      pwr_done_reg <= (pwr_cnt_reg == CW'(PWRUP_CYC - 1));
    end
  end

  // Clock-low and both-high timers, saturating so they keep firing while the condition holds
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      low_cnt_reg <= '0;
    end else if (scl) begin
      low_cnt_reg <= '0;
    end else if (low_cnt_reg != CW'(TOUT_CYC)) begin
      low_cnt_reg <= low_cnt_reg + CW'(1);
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      idle_cnt_reg <= '0;
    end else if (!(scl & sda)) begin
      idle_cnt_reg <= '0;
    end else if (idle_cnt_reg != CW'(IDLE_CYC)) begin
      idle_cnt_reg <= idle_cnt_reg + CW'(1);
    end
  end

  // Enable comes from the configuration bit outside, which resets to off
  assign tout_fire = tout_en_i & (low_cnt_reg == CW'(TOUT_CYC));
  assign idle_fire = ~deep_sleep_i & (idle_cnt_reg == CW'(IDLE_CYC));
  assign bus_reset = stop_det | tout_fire | idle_fire;
  assign step_ok   = pwr_done_reg & ~bus_reset & ~start_det;

  assign byte_full    = (bit_cnt_reg == sbc_pkg::BYTE_BITS);
  assign addr_hit     = (shift_reg[7:1] == sbc_pkg::OWN_ADDR);
  assign wr_byte_done = step_ok & (state_reg == sbc_pkg::ST_WR) & scl_fall & byte_full;
  assign ptr_load     = wr_byte_done & first_reg;
  // No clock stretching, so a full stream is refused by leaving the byte unacknowledged
  assign push         = wr_byte_done & ~first_reg & fifo_in_ready;
  assign rd_next      = step_ok & (state_reg == sbc_pkg::ST_RACK) & scl_fall & host_ack_reg;
  assign load_now     = step_ok & (state_reg == sbc_pkg::ST_RD) & ld_pend_reg;

  // Byte engine; data changes only while the clock is low, the clock is never driven
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg    <= sbc_pkg::ST_IDLE;
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 8'h00;
      tx_reg       <= 8'h00;
      dir_rd_reg   <= 1'b0;
      first_reg    <= 1'b0;
      host_ack_reg <= 1'b0;
      ld_pend_reg  <= 1'b0;
      sda_oe_reg   <= 1'b0;
    end else if (!pwr_done_reg || bus_reset) begin
      state_reg   <= sbc_pkg::ST_IDLE;
      ld_pend_reg <= 1'b0;
      sda_oe_reg  <= 1'b0;
    end else if (start_det) begin
      state_reg   <= sbc_pkg::ST_ADDR;
      bit_cnt_reg <= 4'h0;
      first_reg   <= 1'b1;
      ld_pend_reg <= 1'b0;
      sda_oe_reg  <= 1'b0;
    end else begin
      case (state_reg)
        sbc_pkg::ST_ADDR: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && byte_full) begin
            if (addr_hit) begin
              state_reg  <= sbc_pkg::ST_AACK;
              dir_rd_reg <= shift_reg[0];
              sda_oe_reg <= 1'b1;
            end else begin
              state_reg  <= sbc_pkg::ST_SKIP;
            end
          end
        end
        sbc_pkg::ST_AACK: begin
          if (scl_fall) begin
            sda_oe_reg  <= 1'b0;
            bit_cnt_reg <= 4'h0;
            if (dir_rd_reg) begin
              state_reg   <= sbc_pkg::ST_RD;
              ld_pend_reg <= 1'b1;
            end else begin
              state_reg   <= sbc_pkg::ST_WR;
            end
          end
        end
        sbc_pkg::ST_WR: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && byte_full) begin
            state_reg  <= sbc_pkg::ST_WACK;
            first_reg  <= 1'b0;
            sda_oe_reg <= first_reg | fifo_in_ready;
          end
        end
        sbc_pkg::ST_WACK: begin
          if (scl_fall) begin
            state_reg   <= sbc_pkg::ST_WR;
            sda_oe_reg  <= 1'b0;
            bit_cnt_reg <= 4'h0;
          end
        end
        sbc_pkg::ST_RD: begin
          if (ld_pend_reg) begin
            ld_pend_reg <= 1'b0;
            tx_reg      <= rd_data_i;
            sda_oe_reg  <= ~rd_data_i[7];
          end else if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (byte_full) begin
              state_reg  <= sbc_pkg::ST_RACK;
              sda_oe_reg <= 1'b0;
            end else begin
              tx_reg     <= {tx_reg[6:0], 1'b0};
              sda_oe_reg <= ~tx_reg[6];
            end
          end
        end
        sbc_pkg::ST_RACK: begin
          if (scl_rise) begin
            host_ack_reg <= ~sda;
          end else if (scl_fall) begin
            if (host_ack_reg) begin
              state_reg   <= sbc_pkg::ST_RD;
              bit_cnt_reg <= 4'h0;
              ld_pend_reg <= 1'b1;
            end else begin
              state_reg   <= sbc_pkg::ST_SKIP;
            end
          end
        end
        default: begin
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // Pointer advances after each streamed or acknowledged byte and wraps through the top
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ptr_reg <= '0;
    end else if (ptr_load) begin
      ptr_reg <= shift_reg;
    end else if (push || rd_next) begin
      ptr_reg <= ptr_reg + PW'(1);
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_strobe_reg <= 1'b0;
      sda_out_reg   <= 1'b0;
    end else begin
      rd_strobe_reg <= load_now;
      sda_out_reg   <= 1'b0;
    end
  end

  sbc_fifo #(
    .W     (2 * PW),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_i       (mclk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({ptr_reg, shift_reg}),
    .out_valid_o (wr_valid_o),
    .out_ready_i (wr_ready_i),
    .out_data_o  ({wr_addr_o, wr_data_o})
  );

  assign sda_o       = sda_out_reg;
  assign sda_oe_o    = sda_oe_reg;
  assign rd_addr_o   = ptr_reg;
  assign rd_strobe_o = rd_strobe_reg;
  assign bus_ready_o = pwr_done_reg;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  a_pwrup_quiet: assert property (!pwr_done_reg |-> state_reg == sbc_pkg::ST_IDLE && !sda_oe_o)
    else $error("Bus touched before power-up interval ended");

  a_drive_states: assert property (sda_oe_o |-> (state_reg inside {sbc_pkg::ST_AACK, sbc_pkg::ST_WACK,
                                                  sbc_pkg::ST_RD}) && !sda_o)
    else $error("Data line driven outside acknowledge or read slots");

  a_start_addr: assert property (pwr_done_reg && start_det && !bus_reset |=>
                                 state_reg == sbc_pkg::ST_ADDR && bit_cnt_reg == 4'h0)
    else $error("Start condition not taken");

  a_addr_match: assert property (step_ok && state_reg == sbc_pkg::ST_ADDR && scl_fall && byte_full &&
                                 addr_hit |=> state_reg == sbc_pkg::ST_AACK && sda_oe_o)
    else $error("Own address not acknowledged");

  a_foreign_addr: assert property (state_reg == sbc_pkg::ST_SKIP |-> !sda_oe_o)
    else $error("Data line driven after foreign address");

  a_write_ack: assert property (wr_byte_done && (first_reg || fifo_in_ready) |=>
                                sda_oe_o && state_reg == sbc_pkg::ST_WACK)
    else $error("Received byte not acknowledged");

  // Held until the falling clock edge that ends the acknowledge slot
  a_ack_hold: assert property (state_reg == sbc_pkg::ST_WACK && sda_oe_o && !scl_fall && step_ok |=>
                               state_reg == sbc_pkg::ST_WACK && sda_oe_o)
    else $error("Acknowledge released before its slot ended");

  a_stop_reset: assert property (stop_det |=> state_reg == sbc_pkg::ST_IDLE && !sda_oe_o)
    else $error("Stop did not reset the interface");

  a_tout_abort: assert property (pwr_done_reg && tout_fire |=> state_reg == sbc_pkg::ST_IDLE)
    else $error("Clock-low time-out did not reset");

  a_tout_gate: assert property (low_cnt_reg == CW'(TOUT_CYC) && !tout_en_i && !stop_det && !idle_fire
                                && !start_det && state_reg == sbc_pkg::ST_WR |=>
                                state_reg == sbc_pkg::ST_WR)
    else $error("Time-out acted while disabled");

  a_idle_reset: assert property (pwr_done_reg && idle_fire |=> state_reg == sbc_pkg::ST_IDLE)
    else $error("Idle bus did not reset the interface");

  a_ptr_wrap: assert property (push |=> ptr_reg == $past(ptr_reg) + PW'(1))
    else $error("Pointer did not advance after block byte");

  a_ptr_only: assert property (ptr_load |=> ptr_reg == $past(shift_reg) && !$past(push))
    else $error("Pointer byte mishandled");

  a_reread: assert property (step_ok && state_reg == sbc_pkg::ST_RACK && scl_fall && !host_ack_reg |=>
                             $stable(ptr_reg) && state_reg == sbc_pkg::ST_SKIP)
    else $error("Unacknowledged read moved the pointer");

  a_msb_first: assert property (load_now |=> sda_oe_o == !$past(rd_data_i[7]) && rd_strobe_o)
    else $error("Read byte not started at its top bit");

  c_write_stream: cover property (push ##[1:1000] wr_valid_o);
  c_read_chain: cover property (rd_next ##[1:1000] load_now);
  c_foreign: cover property (state_reg == sbc_pkg::ST_SKIP);
  c_timeout: cover property (tout_fire && state_reg != sbc_pkg::ST_IDLE);

endmodule // sbc_smbus_client

// ==== test/sbc_host_model.sv ====
// Behavioural bus host that drives the two-wire link for the client bench
module sbc_host_model (
  input  wire logic mclk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  // Six low and two high cycles give 320 ns a bit; lo and hi stretch the host's own clock
  task automatic put_bit(input logic b, input int lo, input int hi, output logic seen);
    scl_o <= 1'b0;
    cyc(3 + lo);
    sda_low_o <= ~b;
    cyc(3);
    scl_o <= 1'b1;
    cyc(2 + hi);
    seen = sda_i;
  endtask

  // Long low wait first so a client acknowledge is released before data moves
  task automatic start();
    scl_o <= 1'b0;
    cyc(6);
    sda_low_o <= 1'b0;
    cyc(2);
    scl_o <= 1'b1;
    cyc(4);
    sda_low_o <= 1'b1;
    cyc(4);
  endtask

  task automatic stop();
    scl_o <= 1'b0;
    cyc(6);
    sda_low_o <= 1'b1;
    cyc(2);
    scl_o <= 1'b1;
    cyc(4);
    sda_low_o <= 1'b0;
    cyc(4);
  endtask

  task automatic wr_byte(input logic [7:0] d, input int lo, input int hi, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], (i == 7) ? lo : 0, (i == 7) ? hi : 0, s);
    end
    put_bit(1'b1, 0, 0, s);
    ack = ~s;
  endtask

  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, 0, 0, s);
      d[i] = s;
    end
    put_bit(nack, 0, 0, s);
  endtask
endmodule // sbc_host_model

// ==== test/sbc_smbus_client_tb_top.sv ====
// Self-checking bench for the two-wire bus client
module sbc_smbus_client_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                      mclk       = 1'b0;
  logic                      resetn     = 1'b0;
  logic                      tout_en    = 1'b0;
  logic                      deep_sleep = 1'b0;
  logic                      wr_ready   = 1'b0;
  logic                      quiet      = 1'b0;
  logic                      stall      = 1'b0;
  logic                      scl;
  logic                      sda_low;
  wire logic                 sda_w;
  logic                      sda_o;
  logic                      sda_oe;
  logic [sbc_pkg::PTR_W-1:0] rd_addr;
  wire logic [sbc_pkg::PTR_W-1:0] rd_data;
  logic                      rd_strobe;
  logic                      wr_valid;
  logic [sbc_pkg::PTR_W-1:0] wr_addr;
  logic [sbc_pkg::PTR_W-1:0] wr_data;
  logic                      bus_ready;
  int                        err_count  = 0;
  int                        compares   = 0;
  int                        strobes    = 0;
  logic [15:0]               q[$];

  always #20 mclk = ~mclk;

  // Pull-up on the data wire; the client only ever pulls low
  assign sda_w   = ~sda_low & (sda_oe ? sda_o : 1'b1);
  // Register file stand-in: each register reads as its address folded with a constant
  assign rd_data = rd_addr ^ 8'hA5;

  sbc_host_model host (
    .mclk_i    (mclk),
    .sda_i     (sda_w),
    .scl_o     (scl),
    .sda_low_o (sda_low)
  );

  sbc_smbus_client #(.PWRUP_CYC(50), .TOUT_CYC(200), .IDLE_CYC(100)) dut (
    .mclk_i                 (mclk),
    .resetn_i               (resetn),
    .serial_bus_clock_pin_i (scl),
    .sda_i                  (sda_w),
    .sda_o                  (sda_o),
    .sda_oe_o               (sda_oe),
    .tout_en_i              (tout_en),
    .deep_sleep_i           (deep_sleep),
    .rd_addr_o              (rd_addr),
    .rd_data_i              (rd_data),
    .rd_strobe_o            (rd_strobe),
    .wr_valid_o             (wr_valid),
    .wr_addr_o              (wr_addr),
    .wr_data_o              (wr_data),
    .wr_ready_i             (wr_ready),
    .bus_ready_o            (bus_ready)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  always @(posedge mclk) begin
    wr_ready <= ~stall & ~wr_ready; // Half-rate consumer keeps the output stage under back-pressure
    if (wr_valid === 1'b1 && wr_ready) q.push_back({wr_addr, wr_data});
    if (rd_strobe === 1'b1) strobes++;
    if (quiet) check(sda_oe, 1'b0);
  end

  task automatic wb(input logic [7:0] d, input logic exp);
    logic a;
    host.wr_byte(d, 0, 0, a);
    check(a, exp);
  endtask

  task automatic rb(input logic nack, input logic [7:0] exp);
    logic [7:0] d;
    host.rd_byte(nack, d);
    check(d, exp);
  endtask

  task automatic pop_chk(input logic [15:0] exp);
    logic [15:0] w;
    w = 'x;
    if (q.size() != 0) w = q.pop_front();
    check(w, exp);
  endtask

  task automatic t_early();
    check(bus_ready, 1'b0);
    host.start();
    wb(8'h50, 1'b0);
    host.stop();
    for (int i = 0; i < 200 && bus_ready !== 1'b1; i++) @(posedge mclk);
    check(bus_ready, 1'b1);
  endtask

  task automatic t_wblock();
    host.start();
    wb(8'h50, 1'b1);
    wb(8'hFE, 1'b1);
    wb(8'h11, 1'b1);
    wb(8'h22, 1'b1);
    wb(8'h33, 1'b1);
    host.stop();
    host.cyc(8);
    pop_chk(16'hFE11);
    pop_chk(16'hFF22);
    pop_chk(16'h0033);
  endtask

  task automatic t_send_recv();
    host.start();
    wb(8'h50, 1'b1);
    wb(8'h3C, 1'b1);
    host.stop();
    for (int i = 0; i < 2; i++) begin
      host.start();
      wb(8'h51, 1'b1);
      rb(1'b1, 8'h3C ^ 8'hA5);
      host.stop();
    end
    check(16'(q.size()), 16'h0000);
    wb(8'h50, 1'b0);
    host.stop();
  endtask

  task automatic t_rblock();
    int s0;
    s0 = strobes;
    host.start();
    wb(8'h50, 1'b1);
    wb(8'hFE, 1'b1);
    host.start();
    wb(8'h51, 1'b1);
    rb(1'b0, 8'hFE ^ 8'hA5);
    rb(1'b0, 8'hFF ^ 8'hA5);
    rb(1'b1, 8'h00 ^ 8'hA5);
    host.stop();
    check(16'(strobes - s0), 16'h0003);
    host.start();
    wb(8'h51, 1'b1);
    rb(1'b1, 8'h00 ^ 8'hA5);
    host.stop();
  endtask

  task automatic t_foreign();
    logic [7:0] addrs [3];
    addrs = '{8'h52, 8'hD0, 8'h11};
    quiet = 1'b1;
    foreach (addrs[i]) begin
      host.start();
      wb(addrs[i], 1'b0);
      wb(8'h50, 1'b0);
      host.stop();
    end
    quiet = 1'b0;
    check(16'(q.size()), 16'h0000);
  endtask

  // Stalled consumer: eight FIFO words plus the output stage, then a refused byte
  task automatic t_fifo();
    stall = 1'b1;
    host.start();
    wb(8'h50, 1'b1);
    wb(8'h40, 1'b1);
    for (int i = 0; i < 9; i++) wb(8'(i), 1'b1);
    wb(8'hEE, 1'b0);
    host.stop();
    stall = 1'b0;
    host.cyc(40);
    check(16'(q.size()), 16'h0009);
    for (int i = 0; i < 9; i++) pop_chk({8'(8'h40 + i), 8'(i)});
  endtask

  task automatic t_tout();
    logic a;
    host.start();
    wb(8'h50, 1'b1);
    host.wr_byte(8'h20, 230, 0, a);
    check(a, 1'b1);
    tout_en <= 1'b1;
    host.wr_byte(8'h55, 230, 0, a);
    check(a, 1'b0);
    wb(8'h66, 1'b0);
    host.stop();
    tout_en <= 1'b0;
    host.cyc(8);
    check(16'(q.size()), 16'h0000);
  endtask

  task automatic t_idle();
    logic a;
    deep_sleep <= 1'b1;
    host.start();
    wb(8'h50, 1'b1);
    host.wr_byte(8'hC0, 0, 120, a);
    check(a, 1'b1);
    host.stop();
    deep_sleep <= 1'b0;
    host.start();
    wb(8'h50, 1'b1);
    host.wr_byte(8'hC0, 0, 120, a);
    check(a, 1'b0);
    host.stop();
  endtask

  task automatic wrap_up();
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #400_000;
    err_count++;
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_early();
    t_wblock();
    t_send_recv();
    t_rblock();
    t_foreign();
    t_fifo();
    t_tout();
    t_idle();
    wrap_up();
  end
endmodule // sbc_smbus_client_tb_top
